// ===== inc/cocr_defines.vh
// Register indices, field masks, bus addresses and reset values.
`ifndef COCR_DEFINES_VH
`define COCR_DEFINES_VH

// Two-wire bus slave addresses, direction bit included.
`define COCR_ADDR_WR      8'h88
`define COCR_ADDR_RD      8'h89

// Register indices.
`define COCR_IDX_BOARD    8'h02
`define COCR_IDX_GENERAL  8'h03
`define COCR_IDX_FAMILY   8'h04
`define COCR_IDX_LEVEL    8'h18
`define COCR_IDX_ICONS    8'h19
`define COCR_IDX_GCTRL    8'h20
`define COCR_IDX_HSTART   8'h21
`define COCR_IDX_VSTART   8'h22
`define COCR_IDX_HSIZE    8'h23
`define COCR_IDX_SRCV     8'h24
`define COCR_IDX_DSTV     8'h25
`define COCR_IDX_VRATIO   8'h26
`define COCR_IDX_HWCFG    8'h41
`define COCR_IDX_RATIO_M  8'h71
`define COCR_IDX_RATIO_N  8'h72

// Writable bit masks; bits outside a mask are reserved.
`define COCR_MASK_GENERAL 8'h19
`define COCR_MASK_LEVEL   8'hF0
`define COCR_MASK_ICONS   8'h7F
`define COCR_MASK_GCTRL   8'h87
`define COCR_MASK_VRATIO  8'hDF
`define COCR_MASK_RATIO   8'h3F

// Field positions.
`define COCR_BIT_PWRDN    0
`define COCR_BIT_BTNDIS   3
`define COCR_BIT_SWCFG    4
`define COCR_BIT_FNICON   1
`define COCR_BIT_MAGEN    7
`define COCR_BIT_PACK     2
`define COCR_BIT_OVRD     7
`define COCR_BIT_DROPEN   4

// Value that hands the board over to software programming.
`define COCR_SW_ENTRY     8'h18

// Reset value of every writable register.
`define COCR_RST_REG      8'h00

`endif

// ===== hdl/cocr_regs.v
// Two-wire bus slave and capture/OSD control register bank.
//
// Behaviour
// RULE_01: Board configuration applies only after 18h enables software mode.
// RULE_02: General control bit 0 set puts the device in power-down.
// RULE_03: General bit 3 disables buttons and gates all software features; code gates only board config, icon enables, bars and zoom.
// RULE_04: General bit 4 selects software board config over hardware straps.
// RULE_05: Host copies hardware config into board config, then writes 18h.
// RULE_06: Index 04h reads a fixed eight-bit family code; writes are ignored.
// RULE_07: Level bits 7:4 give OSD bar count, only while function icons show.
// RULE_08: Icon bits 0 to 3 enable menu, function, left-right, up-down icons.
// RULE_09: Icon status bits 6:4 select the highlighted function icon.
// RULE_10: Graphics control bits 1:0 pick zoom quadrant, used only with zoom.
// RULE_11: Graphics control bit 2 selects 565 or 555 pixel packing.
// RULE_12: Graphics bit 7 enables zoom; host keeps it zero in basic mode.
// RULE_13: Outside zoom, horizontal start adds eight times the signed delta.
// RULE_14: Signed ten-bit vertical delta spans two registers, offsets start.
// RULE_15: Capture width field in units of 16 overrides default if bit 7 set.
// RULE_16: Host keeps capture width within line buffer and divider width.
// RULE_17: Host keeps width times lines times two within field memory.
// RULE_18: Source height in units of 8 overrides detected size if bit 7 set.
// RULE_19: Destination height field in units of 8, enabled by bit 7.
// RULE_20: Line drop code: zero drops none, codes 2 to 14 drop one per code+1.
// RULE_21: Ratio bit 4 selects software line drop code over hardware default.
// RULE_22: Vertical scale ratio is N over M, six bits each.
// RULE_23: Two-wire bus access: write address 88h, read 89h, index, data.
// RULE_24: Reserved bits read as zero and writes to them have no effect.
`timescale 1ns/1ps
`include "cocr_defines.vh"

module cocr_regs #(
  parameter [7:0]  FAMILY_CODE  = 8'hA5, // Arbitrary value.
  parameter [11:0] DEF_HSTART   = 12'h090,
  parameter [9:0]  DEF_VSTART   = 10'h020,
  parameter [10:0] DEF_HSIZE    = 11'h280,
  parameter [9:0]  DEF_DSTV     = 10'h0F0,
  parameter [3:0]  DEF_DROP     = 4'h0
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire [7:0]  hw_config_pins,
  input  wire [9:0]  detected_src_height,
  output reg         power_off_bit,
  output reg  [7:0]  active_board_config,
  output reg  [3:0]  osd_bar_count,
  output reg         show_menu_icons,
  output reg         show_function_icons,
  output reg         show_left_right_icon,
  output reg         show_up_down_icon,
  output reg  [2:0]  selected_function_icon,
  output reg         magnify_enable,
  output reg  [1:0]  zoom_quadrant,
  output reg         pixel_packing_select,
  output reg  [11:0] capture_hstart,
  output reg  [9:0]  capture_vstart,
  output reg  [10:0] capture_width,
  output reg  [9:0]  source_height,
  output reg  [9:0]  dest_height,
  output reg  [3:0]  line_drop_code,
  output reg  [5:0]  ratio_numerator,
  output reg  [5:0]  ratio_denominator
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_IDX  = 3'd2;
  localparam [2:0] ST_WDAT = 3'd3;
  localparam [2:0] ST_RDAT = 3'd4;

  // Pin synchronisers; the first stage feeds only the second.
  reg        scl_s1_reg;
  reg        scl_s2_reg;
  reg        scl_d_reg;
  reg        sda_s1_reg;
  reg        sda_s2_reg;
  reg        sda_d_reg;
  reg  [7:0] hw_s1_reg;
  reg  [7:0] hw_s2_reg;

  reg  [2:0] state_reg;
  reg  [3:0] bcnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] index_reg;
  reg        rd_mode_reg;
  reg        ack_reg;

  reg  [7:0] board_reg;
  reg  [7:0] general_reg;
  reg  [7:0] level_reg;
  reg  [7:0] icons_reg;
  reg  [7:0] gctrl_reg;
  reg  [7:0] hstart_reg;
  reg  [7:0] vstart_reg;
  reg  [7:0] hsize_reg;
  reg  [7:0] srcv_reg;
  reg  [7:0] dstv_reg;
  reg  [7:0] vratio_reg;
  reg  [7:0] ratio_m_reg;
  reg  [7:0] ratio_n_reg;

  reg  [7:0] rdata;
  reg        wr_stb;
  reg  [7:0] wr_data;

  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_c  = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_c   = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
      hw_s1_reg  <= 8'h00;
      hw_s2_reg  <= 8'h00;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
      hw_s1_reg  <= hw_config_pins;
      hw_s2_reg  <= hw_s1_reg;
    end
  end

  // Read data; unlisted indices and reserved bits read as zero.
  always @* begin
    case (index_reg)
      `COCR_IDX_BOARD:   rdata = board_reg;
      `COCR_IDX_GENERAL: rdata = general_reg;
      // Fixed family code
      `COCR_IDX_FAMILY:  rdata = FAMILY_CODE;
      `COCR_IDX_LEVEL:   rdata = level_reg;
      `COCR_IDX_ICONS:   rdata = icons_reg;
      `COCR_IDX_GCTRL:   rdata = gctrl_reg;
      `COCR_IDX_HSTART:  rdata = hstart_reg;
      `COCR_IDX_VSTART:  rdata = vstart_reg;
      `COCR_IDX_HSIZE:   rdata = hsize_reg;
      `COCR_IDX_SRCV:    rdata = srcv_reg;
      `COCR_IDX_DSTV:    rdata = dstv_reg;
      `COCR_IDX_VRATIO:  rdata = vratio_reg;
      `COCR_IDX_HWCFG:   rdata = hw_s2_reg;
      `COCR_IDX_RATIO_M: rdata = ratio_m_reg;
      `COCR_IDX_RATIO_N: rdata = ratio_n_reg;
      default:           rdata = 8'h00;
    endcase
  end

  // RULE_23: two-wire slave
  // The slave drives on falling clock edges only, so data is stable
  // long before the host samples it on the next rising edge.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      bcnt_reg    <= 4'h0;
      shift_reg   <= 8'h00;
      index_reg   <= 8'h00;
      rd_mode_reg <= 1'b0;
      ack_reg     <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      wr_stb      <= 1'b0;
      wr_data     <= 8'h00;
    end else begin
      wr_stb  <= 1'b0;
      sda_out <= 1'b0;
      if (start_c) begin
        state_reg <= ST_ADDR;
        bcnt_reg  <= 4'h0;
        ack_reg   <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_c) begin
        state_reg <= ST_IDLE;
        ack_reg   <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (state_reg != ST_IDLE) begin
        if (scl_rise) begin
          if (ack_reg) begin
            // A host that does not acknowledge ends the read burst.
            if (state_reg == ST_RDAT && sda_s2_reg) begin
              state_reg <= ST_IDLE;
            end
          end else begin
            if (state_reg != ST_RDAT) begin
              shift_reg <= {shift_reg[6:0], sda_s2_reg};
            end
            bcnt_reg <= bcnt_reg + 4'h1;
          end
        end else if (scl_fall) begin
          if (ack_reg) begin
            ack_reg  <= 1'b0;
            bcnt_reg <= 4'h0;
            if (state_reg == ST_RDAT) begin
              shift_reg <= rdata;
              sda_oe    <= ~rdata[7];
            end else begin
              sda_oe <= 1'b0;
            end
          end else if (bcnt_reg == 4'h8) begin
            ack_reg <= 1'b1;
            case (state_reg)
              ST_ADDR: begin
                if (shift_reg == `COCR_ADDR_WR ||
                    shift_reg == `COCR_ADDR_RD) begin
                  rd_mode_reg <= shift_reg[0];
                  state_reg   <= ST_IDX;
                  sda_oe      <= 1'b1;
                end else begin
                  state_reg <= ST_IDLE;
                  ack_reg   <= 1'b0;
                end
              end
              ST_IDX: begin
                index_reg <= shift_reg;
                state_reg <= rd_mode_reg ? ST_RDAT : ST_WDAT;
                sda_oe    <= 1'b1;
              end
              ST_WDAT: begin
                wr_stb  <= 1'b1;
                wr_data <= shift_reg;
                sda_oe  <= 1'b1;
              end
              ST_RDAT: begin
                // Release the line so the host can answer.
                index_reg <= index_reg + 8'h01;
                sda_oe    <= 1'b0;
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end else if (state_reg == ST_RDAT) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe    <= ~shift_reg[6];
          end
        end else if (wr_stb) begin
          // Index advances on the same clock edge as the write lands.
          index_reg <= index_reg + 8'h01;
        end
      end
    end
  end

  // Register writes; unlisted and read-only indices drop the data.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      board_reg   <= `COCR_RST_REG;
      general_reg <= `COCR_RST_REG;
      level_reg   <= `COCR_RST_REG;
      icons_reg   <= `COCR_RST_REG;
      gctrl_reg   <= `COCR_RST_REG;
      hstart_reg  <= `COCR_RST_REG;
      vstart_reg  <= `COCR_RST_REG;
      hsize_reg   <= `COCR_RST_REG;
      srcv_reg    <= `COCR_RST_REG;
      dstv_reg    <= `COCR_RST_REG;
      vratio_reg  <= `COCR_RST_REG;
      ratio_m_reg <= `COCR_RST_REG;
      ratio_n_reg <= `COCR_RST_REG;
    end else if (wr_stb) begin
      // RULE_24: reserved bits masked
      case (index_reg)
        `COCR_IDX_BOARD:   board_reg   <= wr_data;
        `COCR_IDX_GENERAL: general_reg <= wr_data & `COCR_MASK_GENERAL;
        `COCR_IDX_LEVEL:   level_reg   <= wr_data & `COCR_MASK_LEVEL;
        `COCR_IDX_ICONS:   icons_reg   <= wr_data & `COCR_MASK_ICONS;
        `COCR_IDX_GCTRL:   gctrl_reg   <= wr_data & `COCR_MASK_GCTRL;
        `COCR_IDX_HSTART:  hstart_reg  <= wr_data;
        `COCR_IDX_VSTART:  vstart_reg  <= wr_data;
        `COCR_IDX_HSIZE:   hsize_reg   <= wr_data;
        `COCR_IDX_SRCV:    srcv_reg    <= wr_data;
        `COCR_IDX_DSTV:    dstv_reg    <= wr_data;
        `COCR_IDX_VRATIO:  vratio_reg  <= wr_data & `COCR_MASK_VRATIO;
        `COCR_IDX_RATIO_M: ratio_m_reg <= wr_data & `COCR_MASK_RATIO;
        `COCR_IDX_RATIO_N: ratio_n_reg <= wr_data & `COCR_MASK_RATIO;
        // RULE_06: family code ignores writes
        default: ;
      endcase
    end
  end

  wire        sw_mode  = general_reg[`COCR_BIT_BTNDIS];
  wire        sw_cfg   = general_reg[`COCR_BIT_SWCFG];
  wire        zoom_on  = sw_mode & gctrl_reg[`COCR_BIT_MAGEN];
  wire [11:0] hdelta   = {hstart_reg[7], hstart_reg, 3'b000};
  wire [9:0]  vdelta   = {vstart_reg, vratio_reg[7:6]};

  // Derived controls are registered so every output is a flip-flop.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      power_off_bit          <= 1'b0;
      active_board_config    <= 8'h00;
      osd_bar_count          <= 4'h0;
      show_menu_icons        <= 1'b0;
      show_function_icons    <= 1'b0;
      show_left_right_icon   <= 1'b0;
      show_up_down_icon      <= 1'b0;
      selected_function_icon <= 3'h0;
      magnify_enable         <= 1'b0;
      zoom_quadrant          <= 2'h0;
      pixel_packing_select   <= 1'b0;
      capture_hstart         <= 12'h000;
      capture_vstart         <= 10'h000;
      capture_width          <= 11'h000;
      source_height          <= 10'h000;
      dest_height            <= 10'h000;
      line_drop_code         <= 4'h0;
      ratio_numerator        <= 6'h00;
      ratio_denominator      <= 6'h00;
    end else begin
      // RULE_02: power-down bit
      power_off_bit <= general_reg[`COCR_BIT_PWRDN];
      // RULE_01: software config gating
      // RULE_04: software config select
      active_board_config <= (sw_mode & sw_cfg) ? board_reg : hw_s2_reg;
      // RULE_03: features need button disable
      // RULE_08: icon enables
      show_menu_icons      <= sw_mode & icons_reg[0];
      show_function_icons  <= sw_mode & icons_reg[`COCR_BIT_FNICON];
      show_left_right_icon <= sw_mode & icons_reg[2];
      show_up_down_icon    <= sw_mode & icons_reg[3];
      // RULE_09: highlighted icon
      selected_function_icon <= icons_reg[6:4];
      // RULE_07: bar count gated by icons
      osd_bar_count <= (sw_mode & icons_reg[`COCR_BIT_FNICON]) ?
                       level_reg[7:4] : 4'h0;
      // RULE_12: zoom enable
      magnify_enable <= zoom_on;
      // RULE_10: quadrant only while zooming
      zoom_quadrant  <= zoom_on ? gctrl_reg[1:0] : 2'h0;
      // RULE_11: pixel packing select
      pixel_packing_select <= gctrl_reg[`COCR_BIT_PACK];
      // RULE_13: horizontal start offset
      capture_hstart <= zoom_on ? DEF_HSTART : DEF_HSTART + hdelta;
      // RULE_14: ten-bit vertical offset
      capture_vstart <= zoom_on ? DEF_VSTART : DEF_VSTART + vdelta;
      // RULE_15: width override
      capture_width <= hsize_reg[`COCR_BIT_OVRD] ?
                       {hsize_reg[6:0], 4'h0} : DEF_HSIZE;
      // RULE_18: source height override
      source_height <= srcv_reg[`COCR_BIT_OVRD] ?
                       {srcv_reg[6:0], 3'b000} : detected_src_height;
      // RULE_19: destination height enable
      dest_height <= dstv_reg[`COCR_BIT_OVRD] ?
                     {dstv_reg[6:0], 3'b000} : DEF_DSTV;
      // RULE_20: line drop code passed on
      // RULE_21: software ratio select
      line_drop_code <= vratio_reg[`COCR_BIT_DROPEN] ?
                        vratio_reg[3:0] : DEF_DROP;
      // RULE_22: N over M
      ratio_numerator   <= ratio_n_reg[5:0];
      ratio_denominator <= ratio_m_reg[5:0];
    end
  end

endmodule

// ===== bench/cocr_host_model.sv
// Two-wire bus host that reaches the register bank from the far side.
`timescale 1ns/1ps
module cocr_host_model (
  input  logic mclk,
  input  logic sda,
  output logic scl,
  output logic sda_pull
);
  integer nacks;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 0;
  end
  task hold(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task start();
    hold(4);
    sda_pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b1;
    hold(8);
    scl = 1'b0;
  endtask
  task stop();
    hold(4);
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_pull = 1'b0;
    hold(8);
  endtask
  // Data changes only mid-low so setup and hold both get four cycles.
  task xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hold(4);
      sda_pull = ~tx[i];
      hold(4);
      scl = 1'b1;
      hold(4);
      rx[i] = sda;
      hold(4);
      scl = 1'b0;
    end
  endtask
  task send(input logic [7:0] b);
    logic [8:0] r;
    xbyte({b, 1'b1}, r);
    if (r[0] !== 1'b0)
      nacks++;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send(8'h88);
    send(a);
    send(d);
    stop();
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start();
    send(8'h89);
    send(a);
    xbyte(9'h1FF, r);
    d = r[8:1];
    stop();
  endtask
endmodule

// ===== bench/cocr_regs_checker.sv
// Port assertions for the capture and OSD register bank.
`timescale 1ns/1ps
module cocr_regs_checker #(
  parameter [11:0] DEF_HSTART = 12'h090,
  parameter [9:0]  DEF_VSTART = 10'h020,
  parameter [10:0] DEF_HSIZE  = 11'h280,
  parameter [9:0]  DEF_DSTV   = 10'h0F0
) (
  input logic        mclk,
  input logic        reset_n,
  input logic        scl_in,
  input logic        sda_out,
  input logic        sda_oe,
  input logic [3:0]  osd_bar_count,
  input logic        show_function_icons,
  input logic        magnify_enable,
  input logic [1:0]  zoom_quadrant,
  input logic [11:0] capture_hstart,
  input logic [9:0]  capture_vstart,
  input logic [10:0] capture_width,
  input logic [9:0]  dest_height
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_scl_high;
    scl_in [*4];
  endsequence
  sequence s_answer;
    $rose(sda_oe);
  endsequence
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data output driven high");
  a_answer_low: assert property (s_answer |-> !scl_in)
    else $error("data pulled while clock high");
  a_oe_steady: assert property (s_scl_high |-> $stable(sda_oe))
    else $error("data changed while clock high");
  a_quad_zoom: assert property (
    zoom_quadrant != 2'b00 |-> magnify_enable)
    else $error("quadrant set without zoom");
  a_bars_icons: assert property (
    osd_bar_count != 4'h0 |-> show_function_icons)
    else $error("bars shown without icons");
  a_zoom_start: assert property (magnify_enable |->
    capture_hstart == DEF_HSTART && capture_vstart == DEF_VSTART)
    else $error("start offset applied in zoom");
  a_hstart_step: assert property (
    capture_hstart[2:0] == DEF_HSTART[2:0])
    else $error("start not in steps of eight");
  a_width_units: assert property (capture_width[3:0] == 4'h0 ||
    capture_width == DEF_HSIZE)
    else $error("width not in units of sixteen");
  a_dest_units: assert property (dest_height[2:0] == 3'h0 ||
    dest_height == DEF_DSTV)
    else $error("height not in units of eight");
endmodule
bind cocr_regs cocr_regs_checker #(
  .DEF_HSTART(DEF_HSTART), .DEF_VSTART(DEF_VSTART),
  .DEF_HSIZE(DEF_HSIZE), .DEF_DSTV(DEF_DSTV)
) u_checker (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .osd_bar_count(osd_bar_count),
  .show_function_icons(show_function_icons),
  .magnify_enable(magnify_enable), .zoom_quadrant(zoom_quadrant),
  .capture_hstart(capture_hstart), .capture_vstart(capture_vstart),
  .capture_width(capture_width), .dest_height(dest_height)
);

// ===== bench/cocr_regs_tb.sv
// Self-checking bench for the capture and OSD register bank.
`timescale 1ns/1ps
module cocr_regs_tb;
  localparam [7:0] FAM = 8'h3C; // Arbitrary family code.
  localparam [11:0] DH = 12'h0A8;
  localparam [9:0] DV = 10'h031;
  localparam [10:0] DW = 11'h2D0;
  localparam [9:0] DD = 10'h0C8;
  localparam [3:0] DR = 4'h5;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] hw = 8'h00;
  logic [9:0] det = 10'h000;
  logic [7:0] sh [0:255];
  logic [7:0] rl [0:14] = '{8'h02, 8'h03, 8'h04, 8'h18, 8'h19, 8'h20,
    8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h41, 8'h71, 8'h72};
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  wire        scl;
  wire        pull;
  wire        sda_oe;
  wire        sda;
  // The bus line has a pull-up, so a released line reads high.
  assign sda = ~(pull | sda_oe);
  always #5 mclk = ~mclk;
  cocr_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));
  cocr_regs #(
    .FAMILY_CODE(FAM), .DEF_HSTART(DH), .DEF_VSTART(DV),
    .DEF_HSIZE(DW), .DEF_DSTV(DD), .DEF_DROP(DR)
  ) DUT (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .hw_config_pins(hw),
    .detected_src_height(det), .power_off_bit(), .active_board_config(),
    .osd_bar_count(), .show_menu_icons(), .show_function_icons(),
    .show_left_right_icon(), .show_up_down_icon(),
    .selected_function_icon(), .magnify_enable(), .zoom_quadrant(),
    .pixel_packing_select(), .capture_hstart(), .capture_vstart(),
    .capture_width(), .source_height(), .dest_height(),
    .line_drop_code(), .ratio_numerator(), .ratio_denominator()
  );
  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h03: msk = 8'h19;
      8'h18: msk = 8'hF0;
      8'h19: msk = 8'h7F;
      8'h20: msk = 8'h87;
      8'h26: msk = 8'hDF;
      8'h71, 8'h72: msk = 8'h3F;
      8'h02, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25: msk = 8'hFF;
      default: msk = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] rexp(input logic [7:0] a);
    rexp = (a == 8'h04) ? FAM : (a == 8'h41) ? hw : sh[a];
  endfunction
  task put(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    sh[a] = d & msk(a);
  endtask
  task check_all();
    logic [7:0] g;
    logic [11:0] hs;
    logic [9:0] vs;
    logic m;
    g = sh[8'h03];
    m = sh[8'h20][7] & g[3];
    hs = m ? DH : DH + {sh[8'h21][7], sh[8'h21], 3'h0};
    vs = m ? DV : DV + {sh[8'h22], sh[8'h26][7:6]};
    chk(DUT.active_board_config, (g[3] & g[4]) ? sh[8'h02] : hw);
    chk(DUT.power_off_bit, g[0]);
    chk(DUT.osd_bar_count,
      (g[3] & sh[8'h19][1]) ? sh[8'h18][7:4] : 4'h0);
    chk({DUT.show_up_down_icon, DUT.show_left_right_icon,
      DUT.show_function_icons, DUT.show_menu_icons}, sh[8'h19][3:0] & {4{g[3]}});
    chk(DUT.selected_function_icon, sh[8'h19][6:4]);
    chk({DUT.magnify_enable, DUT.zoom_quadrant},
      {m, m ? sh[8'h20][1:0] : 2'b00});
    chk(DUT.pixel_packing_select, sh[8'h20][2]);
    chk(DUT.capture_hstart, hs);
    chk(DUT.capture_vstart, vs);
    chk(DUT.capture_width,
      sh[8'h23][7] ? {sh[8'h23][6:0], 4'h0} : DW);
    chk(DUT.source_height,
      sh[8'h24][7] ? {sh[8'h24][6:0], 3'h0} : det);
    chk(DUT.dest_height,
      sh[8'h25][7] ? {sh[8'h25][6:0], 3'h0} : DD);
    chk(DUT.line_drop_code, sh[8'h26][4] ? sh[8'h26][3:0] : DR);
    chk({DUT.ratio_numerator, DUT.ratio_denominator},
      {sh[8'h72][5:0], sh[8'h71][5:0]});
  endtask
  initial begin
    logic [7:0] v;
    logic [7:0] a;
    logic [7:0] d;
    foreach (sh[k]) sh[k] = 8'h00;
    void'($urandom(16153));
    hw = 8'($urandom);
    det = 10'($urandom);
    repeat (2) @(posedge mclk);
    @(negedge mclk) reset_n = 1'b1;
    foreach (rl[i]) begin
      host.rd(rl[i], v);
      chk(v, rexp(rl[i]));
    end
    check_all();
    $display("test reset values finished");
    foreach (rl[i]) begin
      // width and line count kept legal
      d = (rl[i] == 8'h23) ? 8'hB2 : (rl[i] == 8'h25) ? 8'h9E : 8'hFF;
      put(rl[i], d);
      host.rd(rl[i], v);
      chk(v, rexp(rl[i]));
    end
    put(8'h30, 8'hFF);
    chk(host.nacks, 0);
    check_all();
    $display("test all ones finished");
    host.start();
    host.send(8'h90);
    host.stop();
    chk(host.nacks, 1);
    $display("test foreign address finished");
    // zoom off before leaving software mode
    put(8'h20, 8'h00);
    put(8'h03, 8'h00);
    put(8'h02, ~hw);
    chk(DUT.active_board_config, hw);
    // copy straps then enter software mode
    host.rd(8'h41, v);
    put(8'h02, v);
    put(8'h03, 8'h18);
    chk(DUT.active_board_config, hw);
    hw = ~hw;
    repeat (4) @(negedge mclk);
    chk(DUT.active_board_config, v);
    $display("test software entry finished");
    put(8'h22, 8'h80);
    for (int c = 0; c < 16; c++) begin
      put(8'h26, 8'h50 | 8'(c));
      put(8'h21, c[0] ? 8'h80 : 8'h7F);
      check_all();
    end
    $display("test line drop codes finished");
    for (int n = 0; n < 30; n++) begin
      a = rl[$urandom_range(0, 14)];
      d = 8'($urandom);
      hw = 8'($urandom);
      det = 10'($urandom);
      if (a == 8'h23)
        d[6:0] = 7'($urandom_range(0, 50));
      if (a == 8'h25)
        d[6:0] = 7'($urandom_range(0, 30));
      if (a == 8'h20 && !sh[8'h03][3])
        d[7] = 1'b0;
      if (a == 8'h03 && sh[8'h20][7])
        d[3] = 1'b1;
      put(a, d);
      host.rd(a, v);
      chk(v, rexp(a));
      check_all();
    end
    chk(host.nacks, 1);
    $display("test random traffic finished");
    report_and_stop();
  end
endmodule
